// [hdl/pulsar_axis_regs.svh]
/*
 * register offsets, field positions, mode and command codes of the pulsar axis
 * assumes: included by the axis module and the bench
 */
`ifndef PULSAR_AXIS_REGS_SVH
`define PULSAR_AXIS_REGS_SVH
// ****************************************
// register offsets
// ****************************************
`define OFS_CTRL      8'h00
`define OFS_CMD       8'h04
`define OFS_MOVE      8'h08
`define OFS_CMDPOS    8'h0c
`define OFS_MECHPOS   8'h10
`define OFS_STATUS    8'h14
`define OFS_EXTERR    8'h18
`define OFS_REMAIN    8'h1c
// ****************************************
// fields and codes
// ****************************************
`define BIT_OVERFLOW  14
`define CTRL_RESET    32'h0000_0000
`define MODE_CONT     7'h01
`define MODE_INC      7'h51
`define MODE_ABS_CMD  7'h52
`define MODE_ABS_MECH 7'h53
`define MODE_ZR_CMD   7'h54
`define MODE_ZR_MECH  7'h55
`define MODE_LIN1_C   7'h68
`define MODE_LIN1     7'h69
`define MODE_LIN2_C   7'h6a
`define MODE_LIN2     7'h6b
`define MODE_CW       7'h6c
`define MODE_CCW      7'h6d
`define CMD_START     8'h50
`define CMD_STOP      8'h49
`define PEND_MAX      9'sh0ff
`define MAG_1X        2'h0
`define MAG_2X        2'h1
`endif

// [hdl/pulsar_axis_pkg.sv]
/*
 * types of the pulsar axis
 * assumes: nothing beyond the register header
 */
package pulsar_axis_pkg;
    // ****************************************
    // types
    // ****************************************
    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_RUN  = 3'b010,
        S_STOP = 3'b100
    } state_t;
    typedef struct packed {
        logic [18:0] spare;
        logic        whole;
        logic [1:0]  mag;
        logic        updown;
        logic        invert;
        logic        spare7;
        logic [6:0]  mode;
    } ctrl_t;
    typedef struct packed {
        logic        ok;
        logic        counted;
        logic        fixed;
        logic        positive;
        logic [31:0] count;
    } plan_t;
endpackage : pulsar_axis_pkg

// [hdl/pulsar_axis.sv]
/*
 * one axis fed by a manual pulse generator, registers on APB
 * assumes: pulser and limit inputs synchronous to pclk, zero-wait APB master
 */
`timescale 1ns/1ps
`include "pulsar_axis_regs.svh"
module pulsar_axis
    import pulsar_axis_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        pulser_phase_a,
    input  wire logic        pulser_phase_b,
    input  wire logic        end_limit_plus,
    input  wire logic        end_limit_minus,
    output logic             pulse_out,
    output logic             dir_out
);
    // ****************************************
    // functions
    // ****************************************
    function automatic plan_t start_plan(input logic [6:0] mode, input logic [31:0] mv,
                                         input logic [31:0] cp, input logic [31:0] mp);
        plan_t p;
        logic [31:0] d;
        p = '0;
        d = '0;
        p.counted = 1'b1;
        case (mode)
            `MODE_INC, `MODE_LIN1, `MODE_LIN2, `MODE_CW: d = mv;
            `MODE_CCW:      d = 32'h0 - mv;
            `MODE_ABS_CMD:  d = mv - cp;
            `MODE_ABS_MECH: d = mv - mp;
            `MODE_ZR_CMD:   d = 32'h0 - cp;
            `MODE_ZR_MECH:  d = 32'h0 - mp;
            default:        p.counted = 1'b0;
        endcase
        if (p.counted) begin
            p.fixed    = 1'b1;
            p.positive = !d[31];
            p.count    = d[31] ? 32'h0 - d : d;
            p.ok       = d != 32'h0;
        end else if (mode == `MODE_CONT) begin
            p.ok = 1'b1;
        end else if (mode == `MODE_LIN1_C || mode == `MODE_LIN2_C) begin
            p.ok       = 1'b1;
            p.fixed    = 1'b1;
            p.positive = !mv[31];
        end
        return p;
    endfunction : start_plan

    function automatic logic mapped(input logic [7:0] a);
        return a[1:0] == 2'h0 && a <= `OFS_REMAIN;
    endfunction : mapped

    // ****************************************
    // registers
    // ****************************************
    ctrl_t        ctrl_q;
    state_t       state_q;
    logic [31:0]  move_q;
    logic [31:0]  cmdpos_q;
    logic [31:0]  mechpos_q;
    logic [31:0]  remain_q;
    logic signed [8:0] pend_q;
    logic [1:0]   mult_q;
    logic         counted_q;
    logic         fixed_q;
    logic         fixdir_q;
    logic         latched_q;
    logic         overflow_q;
    logic         a_q;
    logic         b_q;
    logic         pulse_q;
    logic         dir_q;
    logic [31:0]  prdata_q;
    logic         pready_q;
    logic         pslverr_q;

    logic         setup;
    logic         wr;
    logic         start_cmd;
    logic         stop_cmd;
    logic         run_flag;
    logic         step_v;
    logic         step_pos;
    logic         inc_pos;
    logic         blocked;
    logic         accept;
    logic         ovf_evt;
    logic         emit;
    logic         emit_pos;
    logic         el_stop;
    logic [1:0]   mult_top;
    logic [31:0]  pend_mag;
    plan_t        plan;

    assign setup     = psel && !penable;
    assign wr        = psel && penable && pready_q && pwrite && !pslverr_q;
    assign start_cmd = wr && paddr == `OFS_CMD && pwdata[7:0] == `CMD_START;
    assign stop_cmd  = wr && paddr == `OFS_CMD && pwdata[7:0] == `CMD_STOP;
    assign run_flag  = state_q != S_IDLE;
    assign plan      = start_plan(ctrl_q.mode, move_q, cmdpos_q, mechpos_q);
    assign pend_mag  = {23'h0, pend_q[8] ? 9'sh0 - pend_q : pend_q};

    // ****************************************
    // pulse generator decode
    // ****************************************
    always_comb begin
        step_v   = 1'b0;
        step_pos = 1'b0;
        mult_top = 2'h0;
        if (ctrl_q.updown) begin
            step_v   = (pulser_phase_a && !a_q) ^ (pulser_phase_b && !b_q);
            step_pos = (pulser_phase_a && !a_q) ^ ctrl_q.invert;
        end else begin
            step_pos = (pulser_phase_a ^ b_q) ^ ctrl_q.invert;
            case (ctrl_q.mag)
                `MAG_1X: step_v = pulser_phase_a && !a_q && pulser_phase_b == b_q;
                `MAG_2X: begin
                    step_v   = (pulser_phase_a ^ a_q) && pulser_phase_b == b_q;
                    mult_top = 2'h1;
                end
                default: begin
                    step_v   = (pulser_phase_a ^ a_q) ^ (pulser_phase_b ^ b_q);
                    mult_top = 2'h3;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_q <= 1'b0;
            b_q <= 1'b0;
        end else begin
            a_q <= pulser_phase_a;
            b_q <= pulser_phase_b;
        end
    end

    // ****************************************
    // step buffer and pulse emission
    // ****************************************
    assign inc_pos  = fixed_q ? fixdir_q : step_pos;
    assign blocked  = inc_pos ? end_limit_plus : end_limit_minus;
    assign accept   = run_flag && step_v && !(blocked && !counted_q)
                      && !(counted_q && pend_mag >= remain_q);
    assign ovf_evt  = accept && (inc_pos ? pend_q == `PEND_MAX : pend_q == -`PEND_MAX);
    assign emit_pos = !pend_q[8];
    assign emit     = run_flag && !pulse_q && pend_q != 9'sh0
                      && !(emit_pos ? end_limit_plus : end_limit_minus)
                      && !(state_q == S_STOP && mult_q == 2'h0);
    assign el_stop  = counted_q && (fixdir_q ? end_limit_plus : end_limit_minus);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= 9'sh0;
        end else if (!run_flag || (!counted_q && (pend_q[8] ? end_limit_minus : end_limit_plus)
                                   && pend_q != 9'sh0)) begin
            pend_q <= 9'sh0;
        end else begin
            pend_q <= pend_q + ((accept && !ovf_evt) ? (inc_pos ? 9'sh1 : -9'sh1) : 9'sh0)
                             - (emit ? (emit_pos ? 9'sh1 : -9'sh1) : 9'sh0);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_q <= 1'b0;
            dir_q   <= 1'b1;
        end else begin
            pulse_q <= emit;
            if (emit) begin
                dir_q <= emit_pos;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mult_q <= 2'h0;
        end else if (start_cmd && state_q == S_IDLE) begin
            mult_q <= 2'h0;
        end else if (emit) begin
            mult_q <= mult_q == mult_top ? 2'h0 : mult_q + 2'h1;
        end
    end

    // ****************************************
    // run control
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q   <= S_IDLE;
            counted_q <= 1'b0;
            fixed_q   <= 1'b0;
            fixdir_q  <= 1'b1;
            remain_q  <= 32'h0;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (start_cmd && plan.ok && !latched_q) begin
                        state_q   <= S_RUN;
                        counted_q <= plan.counted;
                        fixed_q   <= plan.fixed;
                        fixdir_q  <= plan.positive;
                        remain_q  <= plan.count;
                    end
                end
                S_RUN, S_STOP: begin
                    if (emit && counted_q) begin
                        remain_q <= remain_q - 32'h1;
                    end
                    if ((counted_q && remain_q == 32'h0) || el_stop) begin
                        state_q <= S_IDLE;
                    end else if (stop_cmd) begin
                        state_q <= (ctrl_q.whole && mult_q != 2'h0) ? S_STOP : S_IDLE;
                    end else if (state_q == S_STOP && mult_q == 2'h0) begin
                        state_q <= S_IDLE;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latched_q <= 1'b0;
        end else if (stop_cmd && ctrl_q.whole && !run_flag) begin
            latched_q <= 1'b1;
        end else if (!ctrl_q.whole) begin
            latched_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_q <= 1'b0;
        end else if (ovf_evt) begin
            overflow_q <= 1'b1;
        end else if (wr && paddr == `OFS_EXTERR && pwdata[`BIT_OVERFLOW]) begin
            overflow_q <= 1'b0;
        end
    end

    // ****************************************
    // software registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `CTRL_RESET;
            move_q <= 32'h0;
        end else if (wr && paddr == `OFS_CTRL) begin
            ctrl_q <= {19'h0, pwdata[12:8], 1'b0, pwdata[6:0]};
        end else if (wr && paddr == `OFS_MOVE) begin
            move_q <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmdpos_q  <= 32'h0;
            mechpos_q <= 32'h0;
        end else begin
            if (wr && paddr == `OFS_CMDPOS) begin
                cmdpos_q <= pwdata;
            end else if (emit) begin
                cmdpos_q <= emit_pos ? cmdpos_q + 32'h1 : cmdpos_q - 32'h1;
            end
            if (wr && paddr == `OFS_MECHPOS) begin
                mechpos_q <= pwdata;
            end else if (emit) begin
                mechpos_q <= emit_pos ? mechpos_q + 32'h1 : mechpos_q - 32'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q  <= 32'h0;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup && !mapped(paddr);
            if (setup && !pwrite) begin
                case (paddr)
                    `OFS_CTRL:    prdata_q <= ctrl_q;
                    `OFS_MOVE:    prdata_q <= move_q;
                    `OFS_CMDPOS:  prdata_q <= cmdpos_q;
                    `OFS_MECHPOS: prdata_q <= mechpos_q;
                    `OFS_STATUS:  prdata_q <= {28'h0, latched_q, state_q == S_STOP, dir_q, run_flag};
                    `OFS_EXTERR:  prdata_q <= {17'h0, overflow_q, 14'h0};
                    `OFS_REMAIN:  prdata_q <= remain_q;
                    default:      prdata_q <= 32'h0;
                endcase
            end else begin
                prdata_q <= 32'h0;
            end
        end
    end

    assign prdata    = prdata_q;
    assign pready    = pready_q;
    assign pslverr   = pslverr_q;
    assign pulse_out = pulse_q;
    assign dir_out   = dir_q;

    // ****************************************
    // assertions
    // ****************************************
    property p_no_pulse_idle;
        @(posedge pclk) disable iff (!presetn) pulse_out |-> $past(run_flag);
    endproperty
    a_no_pulse_idle: assert property (p_no_pulse_idle) else $error("pulse while idle");

    property p_limit_block;
        @(posedge pclk) disable iff (!presetn) $rose(pulse_out) && dir_out |-> !$past(end_limit_plus);
    endproperty
    a_limit_block: assert property (p_limit_block) else $error("pulse into plus limit");

    property p_count_end;
        @(posedge pclk) disable iff (!presetn)
            state_q == S_RUN && counted_q && remain_q == 32'h0 |=> state_q == S_IDLE;
    endproperty
    a_count_end: assert property (p_count_end) else $error("no stop at zero count");

    property p_zero_start;
        @(posedge pclk) disable iff (!presetn)
            start_cmd && state_q == S_IDLE && plan.counted && plan.count == 32'h0
            |=> !run_flag ##1 !pulse_out [*3];
    endproperty
    a_zero_start: assert property (p_zero_start) else $error("zero move ran");

    property p_stop_now;
        @(posedge pclk) disable iff (!presetn)
            stop_cmd && run_flag && !ctrl_q.whole |=> state_q == S_IDLE ##1 !pulse_out;
    endproperty
    a_stop_now: assert property (p_stop_now) else $error("stop not immediate");

    property p_stop_defer;
        @(posedge pclk) disable iff (!presetn)
            stop_cmd && state_q == S_RUN && ctrl_q.whole && mult_q != 2'h0 && !el_stop
            && !(counted_q && remain_q == 32'h0) |=> state_q == S_STOP;
    endproperty
    a_stop_defer: assert property (p_stop_defer) else $error("stop not deferred");

    property p_latch;
        @(posedge pclk) disable iff (!presetn)
            stop_cmd && ctrl_q.whole && !run_flag |=> latched_q;
    endproperty
    a_latch: assert property (p_latch) else $error("stop not latched");

    property p_overflow;
        @(posedge pclk) disable iff (!presetn) ovf_evt |=> overflow_q && pend_mag <= 32'hff;
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow not flagged");

    property p_inc_load;
        @(posedge pclk) disable iff (!presetn)
            start_cmd && state_q == S_IDLE && !latched_q && ctrl_q.mode == `MODE_INC && move_q != 32'h0
            |=> remain_q == (move_q[31] ? 32'h0 - move_q : move_q) && fixdir_q == !move_q[31];
    endproperty
    a_inc_load: assert property (p_inc_load) else $error("move amount not loaded");

    property p_quad_dir;
        @(posedge pclk) disable iff (!presetn)
            step_v && !ctrl_q.updown && !ctrl_q.invert && $rose(pulser_phase_a) && !pulser_phase_b
            |-> step_pos;
    endproperty
    a_quad_dir: assert property (p_quad_dir) else $error("A lead not positive");

    c_run: cover property (@(posedge pclk) disable iff (!presetn) $rose(run_flag) ##[1:50] pulse_out);
    c_defer: cover property (@(posedge pclk) disable iff (!presetn) state_q == S_STOP ##1 state_q == S_IDLE);
    c_count: cover property (@(posedge pclk) disable iff (!presetn) counted_q && $fell(run_flag));
endmodule : pulsar_axis

// [verification/pulser_model.sv]
/*
 * manual pulse generator model driving the two pulser phases
 * assumes: bench raises go for one pclk cycle per step, with a low cycle between steps in up/down mode
 */
`timescale 1ns/1ps
module pulser_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic go,
    input  wire logic fwd,
    input  wire logic updown,
    output logic      phase_a,
    output logic      phase_b
);
    logic [1:0] idx_q;
    logic       up_q;
    logic       dn_q;
    // ****************************************
    // quarter-step sequence, a leads b forward
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idx_q <= 2'h0;
        end else if (go && !updown) begin
            idx_q <= fwd ? idx_q + 2'h1 : idx_q - 2'h1;
        end
    end
    // ****************************************
    // up/down pulses, one cycle high
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_q <= 1'b0;
            dn_q <= 1'b0;
        end else begin
            up_q <= go && updown && fwd;
            dn_q <= go && updown && !fwd;
        end
    end
    assign phase_a = updown ? up_q : idx_q[0] ^ idx_q[1];
    assign phase_b = updown ? dn_q : idx_q[1];
endmodule : pulser_model

// [verification/pulsar_axis_tb.sv]
/*
 * self-checking bench of the pulsar axis: apb master, pulser model, pulse counter
 * assumes: design files compiled first, register header on the include path
 */
`timescale 1ns/1ps
`include "pulsar_axis_regs.svh"
module pulsar_axis_tb;
    import pulsar_axis_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, go, fwd, updown, lim_p, lim_m, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, rd;
    logic [31:0] prdata;
    logic        pready, pslverr, pulse_out, dir_out, pa, pb;
    int          bad_count, checks_done, npos, nneg, cyc, q, e;
    ctrl_t       c;
    logic [6:0]  md [8] = '{`MODE_LIN1, `MODE_LIN2, `MODE_CW, `MODE_CCW, `MODE_LIN1_C, `MODE_LIN2_C, `MODE_INC,
                            `MODE_INC};
    pulsar_axis pulsar_axis_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pulser_phase_a(pa), .pulser_phase_b(pb), .end_limit_plus(lim_p), .end_limit_minus(lim_m),
        .pulse_out(pulse_out), .dir_out(dir_out));
    pulser_model pulser_model_inst (.pclk(pclk), .presetn(presetn), .go(go), .fwd(fwd), .updown(updown),
        .phase_a(pa), .phase_b(pb));
    // ****************************************
    // clock, timeout, pulse counter
    // ****************************************
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (pulse_out === 1'b1) begin
            if (dir_out === 1'b1) npos++;
            else nneg++;
        end
        if (cyc == 60000) begin
            bad_count++;
            complete_run();
        end
    end
    // ****************************************
    // tasks
    // ****************************************
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // pready high ends this wait, else the bench timeout
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic steps(input int n, input logic f);
        for (int k = 0; k < n; k++) begin
            go <= 1'b1; fwd <= f;
            @(posedge pclk);
            go <= 1'b0;
            @(posedge pclk);
        end
        repeat (12) @(posedge pclk);
    endtask : steps
    task automatic start(input ctrl_t cc, input int mv, input int cp, input int mp);
        updown <= cc.updown;
        apb(1'b1, `OFS_CTRL, cc); apb(1'b1, `OFS_MOVE, mv);
        apb(1'b1, `OFS_CMDPOS, cp); apb(1'b1, `OFS_MECHPOS, mp);
        npos = 0; nneg = 0;
        apb(1'b1, `OFS_CMD, {24'h0, `CMD_START});
    endtask : start
    task automatic run(input ctrl_t cc, input int mv, input int cp, input int mp, input int n, input logic f,
                       input int ex);
        start(cc, mv, cp, mp);
        steps(n, f);
        chk(npos, ex > 0 ? ex : 0);
        chk(nneg, ex < 0 ? -ex : 0);
        apb(1'b1, `OFS_CMD, {24'h0, `CMD_STOP});
        $display("test mode %h done", cc.mode);
    endtask : run
    function automatic int mul(input int m);
        return m == 0 ? 1 : (m == 1 ? 2 : 4);
    endfunction : mul
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
        go = 1'b0; fwd = 1'b0; updown = 1'b0; lim_p = 1'b0; lim_m = 1'b0;
        void'($urandom(44303));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({pulse_out, dir_out}, 32'h1);
        apb(1'b0, `OFS_CTRL, 32'h0); chk(rd, `CTRL_RESET);
        apb(1'b0, 8'h20, 32'h0); chk(err, 32'h1);
        c = '0; c.mode = `MODE_CONT; c.mag = 2'h2;
        apb(1'b1, `OFS_CTRL, c); npos = 0; steps(8, 1'b1); chk(npos, 32'h0);
        for (int m = 0; m < 3; m++) for (int i = 0; i < 4; i++) begin
            c.mag = 2'(m);
            c.invert = i[0];
            c.updown = i[1];
            q = 4 * (1 + $urandom % 5);
            fwd <= 1'($urandom);
            e = c.updown ? q : q / 4 * mul(m);
            @(posedge pclk);
            run(c, 0, 0, 0, q, fwd, (fwd ^ c.invert) ? e : -e);
        end
        c = '0; c.mode = `MODE_CONT; c.mag = 2'h2; lim_p <= 1'b1;
        start(c, 0, 0, 0); steps(8, 1'b1); chk(npos, 32'h0);
        steps(8, 1'b0); chk(nneg, 32'h8);
        apb(1'b1, `OFS_CMD, {24'h0, `CMD_STOP}); lim_p <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            c.mode = md[i];
            e = i == 7 ? 0 : 1 + $urandom % 6;
            e = $urandom % 2 ? e : -e;
            // twelve quarter steps keep the pulser on a whole cycle
            q = i inside {4, 5} ? (e < 0 ? -12 : 12) : (i == 3 ? -e : e);
            run(c, e, 0, 0, 12, 1'b1, q);
        end
        q = $urandom % 7; e = $urandom % 7;
        c.mode = `MODE_ABS_CMD; run(c, e, q, 0, 10, 1'b1, e - q);
        c.mode = `MODE_ABS_MECH; run(c, e, 0, q, 10, 1'b1, e - q);
        c.mode = `MODE_ABS_CMD; run(c, 3, 3, 0, 4, 1'b1, 0);
        c.mode = `MODE_ZR_CMD; run(c, 0, -5, 0, 8, 1'b1, 5); apb(1'b0, `OFS_CMDPOS, 0); chk(rd, 0);
        c.mode = `MODE_ZR_MECH; run(c, 0, 0, 4, 8, 1'b1, -4); apb(1'b0, `OFS_STATUS, 0); chk(rd[0], 0);
        c.mode = `MODE_CONT; start(c, 0, 0, 0); go <= 1'b1; fwd <= 1'b1; repeat (600) @(posedge pclk);
        go <= 1'b0; repeat (700) @(posedge pclk);
        apb(1'b0, `OFS_EXTERR, 0); chk(rd[14], 1);
        apb(1'b1, `OFS_EXTERR, 32'h4000); apb(1'b0, `OFS_EXTERR, 0); chk(rd[14], 0);
        apb(1'b1, `OFS_CMD, {24'h0, `CMD_STOP});
        c.mag = `MAG_2X; c.whole = 1'b1; start(c, 0, 0, 0); steps(1, 1'b1);
        apb(1'b1, `OFS_CMD, {24'h0, `CMD_STOP});
        apb(1'b0, `OFS_STATUS, 0);
        chk(rd[2:0], 3'h7);
        steps(2, 1'b1); chk(npos, 2); apb(1'b0, `OFS_STATUS, 0); chk(rd[0], 0);
        apb(1'b1, `OFS_CMD, {24'h0, `CMD_STOP}); apb(1'b0, `OFS_STATUS, 0); chk(rd[3], 1);
        c.whole = 1'b0; apb(1'b1, `OFS_CTRL, c); apb(1'b0, `OFS_STATUS, 0); chk(rd[3], 0);
        $display("test stop handling done");
        complete_run();
    end
endmodule : pulsar_axis_tb
